//--- hw/ppm_top.sv
// parallel port pin mux: two control pins and the low data half
// assumes pin inputs synchronous to SYS_CLK and a synchronous active-high reset
//
// Operation
// [R1] strap high in reset: pin zero carries read strobe, low: general bit a.
// [R2] pin zero function freezes when reset releases.
// [R3] general bit a starts as input after reset.
// [R4] read strobe pin floats in reset, then drives 1.
// [R5] read strobe: async read-enable, sync address strobe, column strobe, sync read-enable.
// [R6] strap high in reset: pin one carries output enable, low: general bit b.
// [R7] pin one function freezes when reset releases.
// [R8] general bit b starts as input after reset.
// [R9] output enable pin floats in reset, then drives 1.
// [R10] output enable pin: async, sync output-enable or row strobe by memory type.
// [R11] strap high: low data half is memory data, inputs after reset.
// [R12] strap low: low data half belongs to the host port.
`timescale 1ns/1ps
`include "ppm_defines.svh"
module ppm_top #(
  parameter int DATA_W = `PPM_DATA_W
) (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic SRST,
  // strap
  input wire logic BOOT_STRAP_PIN,
  // control pins
  input wire logic CTRL_PIN_ZERO_IN,
  output logic CTRL_PIN_ZERO_OUT,
  output logic CTRL_PIN_ZERO_OE_N,
  input wire logic CTRL_PIN_ONE_IN,
  output logic CTRL_PIN_ONE_OUT,
  output logic CTRL_PIN_ONE_OE_N,
  // low data half pins
  input wire logic [DATA_W-1:0] DATA_PIN_IN,
  output logic [DATA_W-1:0] DATA_PIN_OUT,
  output logic [DATA_W-1:0] DATA_PIN_OE_N,
  // general-purpose controller
  input wire logic GPIO_WR,
  input wire logic [1:0] GPIO_DIR_WDATA,
  input wire logic [1:0] GPIO_OUT_WDATA,
  output logic [1:0] GPIO_DIR,
  output logic [1:0] GPIO_IN,
  // memory interface
  input wire ppm_pkg::ppm_mem_type MEM_TYPE,
  input wire logic READ_ENABLE_SELECT_BIT,
  input wire ppm_pkg::ppm_strobe_type MEM_STROBES,
  input wire logic [DATA_W-1:0] MEM_DATA_OUT,
  input wire logic MEM_DATA_DRIVE,
  output logic [DATA_W-1:0] MEM_DATA_LOW_HALF,
  // host port
  input wire logic [DATA_W-1:0] HOST_DATA_OUT,
  input wire logic HOST_DATA_DRIVE,
  output logic [DATA_W-1:0] HOST_PORT_DATA_BUS,
  // selection status
  output logic MEM_SELECTED
);
  if (DATA_W < 1) begin : g_bad_width
    $error("ppm_top: DATA_W must be at least 1");
  end

  logic strap_q;
  logic rst_d1_q;
  ppm_pkg::ppm_state_type state_q;
  logic [1:0] gpio_dir_q;
  logic [1:0] gpio_out_q;
  logic rd_strobe;
  logic oe_strobe;
  logic mem_sel;
  logic gpio_sel;
  logic post_rst;
  logic [DATA_W-1:0] data_val;
  logic data_drive;
  ppm_pkg::ppm_pad_type pad0;
  ppm_pkg::ppm_pad_type pad1;
  ppm_pkg::ppm_pad_type [DATA_W-1:0] dpad;

  // strap sampled only while reset holds
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      strap_q <= BOOT_STRAP_PIN; // R1
    end
  end

  // one-cycle marker of the reset release
  always_ff @(posedge SYS_CLK) begin
    rst_d1_q <= SRST;
  end

  // function fixed at release
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      state_q <= ppm_pkg::ST_RESET;
    end else begin
      case (state_q)
        ppm_pkg::ST_RESET: begin
          state_q <= strap_q ? ppm_pkg::ST_MEM : ppm_pkg::ST_GPIO; // R2 R7
        end
        ppm_pkg::ST_GPIO: begin
          state_q <= ppm_pkg::ST_GPIO;
        end
        ppm_pkg::ST_MEM: begin
          state_q <= ppm_pkg::ST_MEM;
        end
        default: begin
          state_q <= ppm_pkg::ST_RESET;
        end
      endcase
    end
  end

  assign mem_sel = strap_q;
  assign gpio_sel = !strap_q;
  assign post_rst = rst_d1_q;

  // general bits come up as inputs
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      gpio_dir_q <= `PPM_GPIO_DIR_RST; // R3 R8
      gpio_out_q <= `PPM_GPIO_OUT_RST;
    end else if (GPIO_WR && gpio_sel) begin
      gpio_dir_q <= GPIO_DIR_WDATA;
      gpio_out_q <= GPIO_OUT_WDATA;
    end
  end

  // read strobe role by memory type
  always_comb begin
    case (MEM_TYPE)
      ppm_pkg::MEM_ASYNC: rd_strobe = MEM_STROBES.async_re; // R5
      ppm_pkg::MEM_SYNC: begin
        rd_strobe = READ_ENABLE_SELECT_BIT ? MEM_STROBES.sync_re : MEM_STROBES.sync_ads; // R5
      end
      ppm_pkg::MEM_SDRAM: rd_strobe = MEM_STROBES.sdram_cas; // R5
      default: rd_strobe = `PPM_PIN_IDLE;
    endcase
  end

  // output enable role by memory type
  always_comb begin
    case (MEM_TYPE)
      ppm_pkg::MEM_ASYNC: oe_strobe = MEM_STROBES.async_oe; // R10
      ppm_pkg::MEM_SYNC: oe_strobe = MEM_STROBES.sync_oe; // R10
      ppm_pkg::MEM_SDRAM: oe_strobe = MEM_STROBES.sdram_ras; // R10
      default: oe_strobe = `PPM_PIN_IDLE;
    endcase
  end

  // control pin zero: read strobe or general bit a
  ppm_pad u_pad0 (
    .clk(SYS_CLK),
    .srst(SRST),
    .drive_en(mem_sel || gpio_dir_q[`PPM_GPIO_A_BIT]), // R1 R4
    .value(mem_sel ? (post_rst ? `PPM_PIN_IDLE : rd_strobe) : gpio_out_q[`PPM_GPIO_A_BIT]),
    .pad(pad0)
  );

  // control pin one: output enable or general bit b
  ppm_pad u_pad1 (
    .clk(SYS_CLK),
    .srst(SRST),
    .drive_en(mem_sel || gpio_dir_q[`PPM_GPIO_B_BIT]), // R6 R9
    .value(mem_sel ? (post_rst ? `PPM_PIN_IDLE : oe_strobe) : gpio_out_q[`PPM_GPIO_B_BIT]),
    .pad(pad1)
  );

  // low data half owner
  assign data_val = mem_sel ? MEM_DATA_OUT : HOST_DATA_OUT; // R11 R12
  assign data_drive = !post_rst && (mem_sel ? MEM_DATA_DRIVE : HOST_DATA_DRIVE); // R11 R12

  for (genvar i = 0; i < DATA_W; i++) begin : g_dpad
    ppm_pad u_dpad (
      .clk(SYS_CLK),
      .srst(SRST),
      .drive_en(data_drive),
      .value(data_val[i]),
      .pad(dpad[i])
    );
    assign DATA_PIN_OUT[i] = dpad[i].out;
    assign DATA_PIN_OE_N[i] = dpad[i].oe_n;
  end

  assign CTRL_PIN_ZERO_OUT = pad0.out;
  assign CTRL_PIN_ZERO_OE_N = pad0.oe_n;
  assign CTRL_PIN_ONE_OUT = pad1.out;
  assign CTRL_PIN_ONE_OE_N = pad1.oe_n;

  // inputs go only to the selected owner
  assign GPIO_DIR = gpio_dir_q;
  assign GPIO_IN = gpio_sel ? {CTRL_PIN_ONE_IN, CTRL_PIN_ZERO_IN} : 2'h0;
  assign MEM_DATA_LOW_HALF = mem_sel ? DATA_PIN_IN : '0;
  assign HOST_PORT_DATA_BUS = mem_sel ? '0 : DATA_PIN_IN;
  assign MEM_SELECTED = (state_q == ppm_pkg::ST_MEM);

  // checks
  sequence s_release;
    SRST ##1 !SRST;
  endsequence

  sequence s_running;
    !SRST && !rst_d1_q;
  endsequence

  a_strap_frozen: assert property ( // R2 R7
    @(posedge SYS_CLK) !SRST |=> (strap_q == $past(strap_q)))
    else $error("strap changed outside reset");

  a_rd_pin_reset: assert property ( // R4
    @(posedge SYS_CLK) SRST |=> CTRL_PIN_ZERO_OE_N && CTRL_PIN_ONE_OE_N && (&DATA_PIN_OE_N))
    else $error("pin driven during reset");

  a_rd_pin_high: assert property ( // R4
    @(posedge SYS_CLK) s_release ##0 strap_q |=> !CTRL_PIN_ZERO_OE_N && CTRL_PIN_ZERO_OUT)
    else $error("read strobe pin not high after reset");

  a_oe_pin_high: assert property ( // R9
    @(posedge SYS_CLK) s_release ##0 strap_q |=> !CTRL_PIN_ONE_OE_N && CTRL_PIN_ONE_OUT)
    else $error("output enable pin not high after reset");

  a_gpio_as_input: assert property ( // R3 R8
    @(posedge SYS_CLK) s_release ##0 !strap_q |=> CTRL_PIN_ZERO_OE_N && CTRL_PIN_ONE_OE_N)
    else $error("general bit not an input after reset");

  a_data_as_input: assert property ( // R11
    @(posedge SYS_CLK) s_release |=> &DATA_PIN_OE_N)
    else $error("data half driven right after reset");

  a_rd_strobe_role: assert property ( // R5 R1
    @(posedge SYS_CLK) s_running ##0 (strap_q && MEM_TYPE == ppm_pkg::MEM_SYNC)
      |=> CTRL_PIN_ZERO_OUT == ($past(READ_ENABLE_SELECT_BIT) ?
        $past(MEM_STROBES.sync_re) : $past(MEM_STROBES.sync_ads)))
    else $error("read strobe role wrong");

  a_oe_strobe_role: assert property ( // R10 R6
    @(posedge SYS_CLK) s_running ##0 (strap_q && MEM_TYPE == ppm_pkg::MEM_SDRAM)
      |=> CTRL_PIN_ONE_OUT == $past(MEM_STROBES.sdram_ras) && !CTRL_PIN_ONE_OE_N)
    else $error("output enable role wrong");

  a_gpio_route: assert property ( // R1 R6
    @(posedge SYS_CLK) !SRST && !strap_q && gpio_dir_q == 2'h3
      |=> !CTRL_PIN_ZERO_OE_N && CTRL_PIN_ZERO_OUT == $past(gpio_out_q[0])
        && CTRL_PIN_ONE_OUT == $past(gpio_out_q[1]))
    else $error("general bit not on its pin");

  a_host_route: assert property ( // R12
    @(posedge SYS_CLK) s_running ##0 (!strap_q && HOST_DATA_DRIVE)
      |=> DATA_PIN_OUT == $past(HOST_DATA_OUT) && DATA_PIN_OE_N == '0)
    else $error("host data not on data half");

  a_state_stable: assert property ( // R2 R7
    @(posedge SYS_CLK) s_release ##1 (!SRST) [*2] |-> MEM_SELECTED == strap_q)
    else $error("function does not match strap");
endmodule : ppm_top

//--- hw/ppm_defines.svh
// constants for the parallel port pin mux
// assumes inclusion by bare name from the package and the design files
`ifndef PPM_DEFINES_SVH
`define PPM_DEFINES_SVH
`define PPM_DATA_W 16
`define PPM_HIZ_OE_N 1'h1
`define PPM_DRIVE_OE_N 1'h0
`define PPM_PIN_IDLE 1'h1
`define PPM_PAD_OUT_RST 1'h0
`define PPM_GPIO_DIR_RST 2'h0
`define PPM_GPIO_OUT_RST 2'h0
`define PPM_STRAP_RST 1'h0
`define PPM_GPIO_A_BIT 0
`define PPM_GPIO_B_BIT 1
`endif

//--- hw/ppm_pkg.sv
// types for the parallel port pin mux
// assumes ppm_defines.svh sits beside it
`include "ppm_defines.svh"
package ppm_pkg;
  // memory type of the access in progress
  typedef enum logic [1:0] {
    MEM_ASYNC,
    MEM_SYNC,
    MEM_SDRAM
  } ppm_mem_type;

  // pin function after reset
  typedef enum logic [1:0] {
    ST_RESET,
    ST_GPIO,
    ST_MEM
  } ppm_state_type;

  // strobes offered by the memory interface
  typedef struct packed {
    logic async_re;
    logic sync_ads;
    logic sdram_cas;
    logic sync_re;
    logic async_oe;
    logic sync_oe;
    logic sdram_ras;
  } ppm_strobe_type;

  // one pad drive: value and active-low enable
  typedef struct packed {
    logic out;
    logic oe_n;
  } ppm_pad_type;
endpackage : ppm_pkg

//--- hw/ppm_pad.sv
// registered output stage of one two-way pad
// assumes synchronous active-high reset; the pin floats while reset holds
`timescale 1ns/1ps
`include "ppm_defines.svh"
module ppm_pad (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // drive request
  input wire logic drive_en,
  input wire logic value,
  // pad side
  output ppm_pkg::ppm_pad_type pad
);
  ppm_pkg::ppm_pad_type pad_q;

  // float in reset, else follow the request
  always_ff @(posedge clk) begin
    if (srst) begin
      pad_q.out <= `PPM_PAD_OUT_RST;
      pad_q.oe_n <= `PPM_HIZ_OE_N;
    end else begin
      pad_q.out <= value;
      pad_q.oe_n <= drive_en ? `PPM_DRIVE_OE_N : `PPM_HIZ_OE_N;
    end
  end

  assign pad = pad_q;
endmodule : ppm_pad

//--- tb/ppm_mem_model.sv
// memory device on the far side of the low data half
// assumes active-low output enable pin and no pull on the data lines
`timescale 1ns/1ps
module ppm_mem_model #(
  parameter logic [15:0] WORD = 16'hC35A
) (
  // clock
  input wire logic clk,
  // pins seen by the memory
  input wire logic oe_pin_n,
  input wire logic [15:0] dev_out,
  input wire logic [15:0] dev_oe_n,
  // resolved data lines
  output logic [15:0] data
);
  logic [15:0] last_q;
  always_ff @(posedge clk) begin
    last_q <= data;
  end
  // released lines show WORD while oe_pin_n is low, else a changing pattern
  always_comb begin
    if (dev_oe_n[0] == 1'h0) begin
      data = dev_out;
    end else if (oe_pin_n == 1'h0) begin
      data = WORD;
    end else begin
      data = ~last_q;
    end
  end
endmodule : ppm_mem_model

//--- tb/ppm_top_tb.sv
// self-checking bench for the parallel port pin mux
// assumes floating control pins are driven by the bench
`timescale 1ns/1ps
module ppm_top_tb;
  logic clk = 1'h0;
  logic srst = 1'h1;
  logic strap = 1'h1;
  logic ext0 = 1'h1;
  logic ext1 = 1'h1;
  logic gwr = 1'h0;
  logic [1:0] gdir = 2'h0;
  logic [1:0] gout = 2'h0;
  ppm_pkg::ppm_mem_type mtype = ppm_pkg::MEM_ASYNC;
  logic resel = 1'h0;
  ppm_pkg::ppm_strobe_type strb = 7'h7F;
  logic [15:0] mdo = 16'h0000;
  logic mdrv = 1'h0;
  logic [15:0] hdo = 16'h0000;
  logic hdrv = 1'h0;
  logic z_out, z_oe_n, o_out, o_oe_n, msel;
  logic [15:0] d_in, d_out, d_oe_n, mlow, hbus;
  logic [1:0] gdir_seen, gin;
  int n_fail = 0;
  int compares = 0;
  // memory type, select bit, strobes, expected pin zero and pin one
  logic [11:0] rows [9] = '{
    {2'h0, 1'h0, 7'h3F, 2'h1}, {2'h0, 1'h0, 7'h7B, 2'h2},
    {2'h1, 1'h0, 7'h5F, 2'h1}, {2'h1, 1'h1, 7'h5F, 2'h3},
    {2'h1, 1'h1, 7'h77, 2'h1}, {2'h1, 1'h0, 7'h7D, 2'h2},
    {2'h2, 1'h0, 7'h6F, 2'h1}, {2'h2, 1'h0, 7'h7E, 2'h2},
    {2'h2, 1'h1, 7'h77, 2'h3}};
  always #20 clk = ~clk;
  ppm_mem_model ppm_mem_model_inst (.clk(clk), .oe_pin_n(o_oe_n ? ext1 : o_out),
    .dev_out(d_out), .dev_oe_n(d_oe_n), .data(d_in));
  ppm_top ppm_top_inst (.SYS_CLK(clk), .SRST(srst), .BOOT_STRAP_PIN(strap),
    .CTRL_PIN_ZERO_IN(z_oe_n ? ext0 : z_out), .CTRL_PIN_ZERO_OUT(z_out),
    .CTRL_PIN_ZERO_OE_N(z_oe_n), .CTRL_PIN_ONE_IN(o_oe_n ? ext1 : o_out),
    .CTRL_PIN_ONE_OUT(o_out), .CTRL_PIN_ONE_OE_N(o_oe_n), .DATA_PIN_IN(d_in),
    .DATA_PIN_OUT(d_out), .DATA_PIN_OE_N(d_oe_n), .GPIO_WR(gwr),
    .GPIO_DIR_WDATA(gdir), .GPIO_OUT_WDATA(gout), .GPIO_DIR(gdir_seen), .GPIO_IN(gin),
    .MEM_TYPE(mtype), .READ_ENABLE_SELECT_BIT(resel), .MEM_STROBES(strb),
    .MEM_DATA_OUT(mdo), .MEM_DATA_DRIVE(mdrv), .MEM_DATA_LOW_HALF(mlow),
    .HOST_DATA_OUT(hdo), .HOST_DATA_DRIVE(hdrv), .HOST_PORT_DATA_BUS(hbus),
    .MEM_SELECTED(msel));
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic end_sim;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim
  initial begin
    #20000;
    n_fail++;
    end_sim;
  end
  initial begin
    tick(8);
    chk("pins_oe_n", 16'({z_oe_n, o_oe_n}), 16'h3);
    chk("data_oe_n", d_oe_n, 16'hFFFF);
    srst = 1'h0;
    strap = 1'h0;
    tick(1);
    chk("pins_drive", 16'({z_oe_n, z_out, o_oe_n, o_out}), 16'h5);
    chk("mem_sel", 16'(msel), 16'h1);
    chk("data_oe_n", d_oe_n, 16'hFFFF);
    $display("test reset_mem done");
    for (int i = 0; i < 9; i++) begin
      mtype = ppm_pkg::ppm_mem_type'(rows[i][11:10]);
      resel = rows[i][9];
      strb = rows[i][8:2];
      tick(1);
      chk("strobes", 16'({z_out, o_out}), 16'(rows[i][1:0]));
    end
    $display("test strobes done");
    mdrv = 1'h1;
    mdo = 16'hA5C3;
    gwr = 1'h1;
    gdir = 2'h3;
    gout = 2'h3;
    tick(1);
    chk("data_out", d_out, 16'hA5C3);
    chk("data_oe_n", d_oe_n, 16'h0000);
    chk("gpio_dir", 16'(gdir_seen), 16'h0);
    mdrv = 1'h0;
    gwr = 1'h0;
    mtype = ppm_pkg::MEM_ASYNC;
    strb = 7'h7B;
    tick(1);
    chk("mem_data", mlow, 16'hC35A);
    chk("host_data", hbus, 16'h0000);
    chk("gpio_in", 16'(gin), 16'h0);
    chk("mem_sel", 16'(msel), 16'h1);
    strb = 7'h7F;
    $display("test mem_data done");
    srst = 1'h1;
    ext1 = 1'h0;
    tick(8);
    srst = 1'h0;
    strap = 1'h1;
    tick(1);
    chk("pins_oe_n", 16'({z_oe_n, o_oe_n}), 16'h3);
    chk("mem_sel", 16'(msel), 16'h0);
    chk("gpio_in", 16'(gin), 16'h1);
    tick(1);
    chk("pins_oe_n", 16'({z_oe_n, o_oe_n}), 16'h3);
    hdrv = 1'h1;
    hdo = 16'h5A3C;
    tick(1);
    chk("data_out", d_out, 16'h5A3C);
    chk("data_oe_n", d_oe_n, 16'h0000);
    chk("mem_data", mlow, 16'h0000);
    chk("host_data", hbus, 16'h5A3C);
    hdrv = 1'h0;
    gwr = 1'h1;
    gout = 2'h2;
    tick(1);
    gwr = 1'h0;
    chk("gpio_dir", 16'(gdir_seen), 16'h3);
    tick(1);
    chk("pins_drive", 16'({z_oe_n, z_out, o_oe_n, o_out}), 16'h1);
    tick(1);
    chk("pins_drive", 16'({z_oe_n, z_out, o_oe_n, o_out}), 16'h1);
    chk("gpio_in", 16'(gin), 16'h2);
    $display("test gpio done");
    end_sim;
  end
endmodule : ppm_top_tb
